// ### verilog/stc_pkg.sv
// Package for the SYSREF timing calibration block: map, fields, limits
package stc_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses on the register port)
    // ------------------------------------------------------------
    localparam logic [9:0] STC_ADDR_EN = 10'h2b0;
    localparam logic [9:0] STC_ADDR_CFG = 10'h2b1;
    localparam logic [9:0] STC_ADDR_RES0 = 10'h2b2;
    localparam logic [9:0] STC_ADDR_RES1 = 10'h2b3;
    localparam logic [9:0] STC_ADDR_RES2 = 10'h2b4;
    localparam logic [9:0] STC_ADDR_TAD0 = 10'h2b5;
    localparam logic [9:0] STC_ADDR_TAD1 = 10'h2b6;
    localparam logic [9:0] STC_ADDR_TAD2 = 10'h2b7;
    localparam logic [9:0] STC_ADDR_RAMP = 10'h2b8;
    localparam logic [9:0] STC_ADDR_IRQ_STAT = 10'h2c0;
    localparam logic [9:0] STC_ADDR_IRQ_MASK = 10'h2c1;

    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] STC_EN_RST = 8'h00;
    localparam logic [7:0] STC_CFG_RST = 8'h05;
    localparam logic [16:0] STC_TAD_RST = 17'h00000;
    localparam logic [7:0] STC_RAMP_RST = 8'h00;
    localparam logic [1:0] STC_IRQ_RST = 2'h0;
    localparam int STC_EV_DONE = 0;
    localparam int STC_EV_FAIL = 1;
    localparam int STC_DELAY_W = 17;
    localparam int STC_ACC_W = 33;

    // Configuration byte layout
    typedef struct packed {
        logic [3:0] reserved;
        logic [1:0] cal_averaging_select;
        logic [1:0] accum_duration_select;
    } stc_cfg_t;

    // Status field layout, read as three bytes
    typedef struct packed {
        logic [5:0] reserved;
        logic cal_complete_flag;
        logic [16:0] computed_delay_value;
    } stc_result_t;

    // Calibration sequencer, Gray along idle-arm-accum-done
    typedef enum logic [2:0] {
        STC_IDLE = 3'h0,
        STC_ARM = 3'h1,
        STC_ACCUM = 3'h3,
        STC_DONE = 3'h2,
        STC_FAIL = 3'h6
    } stc_state_t;

    // Longest SYSREF period per duration select, in clock cycles
    localparam logic [14:0] STC_LIMIT_0 = 15'd85;
    localparam logic [14:0] STC_LIMIT_1 = 15'd1100;
    localparam logic [14:0] STC_LIMIT_2 = 15'd5200;
    localparam logic [14:0] STC_LIMIT_3 = 15'd21580;

    function automatic logic [14:0] stc_period_limit(input logic [1:0] code);
        stc_period_limit = (code == 2'h0) ? STC_LIMIT_0 :
                           (code == 2'h1) ? STC_LIMIT_1 :
                           (code == 2'h2) ? STC_LIMIT_2 : STC_LIMIT_3;
    endfunction

    // Both selects map code n to 4^(n+1): log2 count is 2n+2
    function automatic logic [4:0] stc_log2_count(input logic [1:0] code);
        stc_log2_count = {2'h0, code, 1'b0} + 5'h02;
    endfunction

endpackage

// ### verilog/stc_sysref_cal.sv
// SYSREF timing calibration: register window, sequencer, delay select
//
// Functional notes
// - Enable low: output follows manual delay register.
// - Enable high: output follows calibrated delay value.
// - Only enable rising edge starts a calibration.
// - Register group decoded at 0x2b0 to 0x2b8.
// - Enable resets 0x00, configuration resets 0x05.
// - Averaging select gives 4/16/64/256 results.
// - Duration select sets accumulation and period limit.
// - Status holds complete flag and 17-bit delay.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps

module stc_sysref_cal
    import stc_pkg::*;
(
    input wire logic i_clk, // Device clock, 250 MHz
    input wire logic i_resetn, // Synchronous reset, active low
    input wire logic [9:0] i_addr, // Register byte address
    input wire logic [7:0] i_wdata, // Register write data
    input wire logic i_wr, // Write strobe
    input wire logic i_rd, // Read strobe
    input wire logic i_sysref, // SYSREF pin, asynchronous
    input wire logic [16:0] i_phase_code, // Phase detector delay code
    output logic [7:0] o_rdata, // Read data, cycle after i_rd
    output logic [16:0] o_aperture_delay, // Applied clock delay
    output logic [7:0] o_ramp_ctrl, // Delay ramp control byte
    output logic o_cal_active, // Sequencer busy
    output logic o_irq // Level interrupt
);

    // ------------------------------------------------------------
    // Register file state
    // ------------------------------------------------------------
    logic en_r;
    logic en_prev_r;
    stc_cfg_t cfg_r;
    logic [16:0] tad_r;
    logic [7:0] ramp_r;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_mask_r;
    logic [7:0] rdata_r;

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    stc_state_t state_r;
    stc_state_t state_nxt;
    stc_cfg_t run_cfg_r;
    logic [14:0] period_cnt_r;
    logic [15:0] samp_cnt_r;
    logic [STC_ACC_W-1:0] acc_r;
    logic [16:0] cal_tad_r;
    logic [16:0] delay_r;
    logic active_r;
    logic irq_r;

    // ------------------------------------------------------------
    // SYSREF synchroniser and edge detect
    // ------------------------------------------------------------
    logic sysref_meta_r;
    logic sysref_sync_r;
    logic sysref_prev_r;
    wire sysref_edge = sysref_sync_r & ~sysref_prev_r;

    // Two flops before any logic sees the pin
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            sysref_meta_r <= 1'b0;
            sysref_sync_r <= 1'b0;
            sysref_prev_r <= 1'b0;
        end
        else
        begin
            sysref_meta_r <= i_sysref;
            sysref_sync_r <= sysref_meta_r;
            sysref_prev_r <= sysref_sync_r;
        end
    end

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    wire wr_en = i_wr && (i_addr == STC_ADDR_EN);
    wire wr_cfg = i_wr && (i_addr == STC_ADDR_CFG);
    wire wr_tad0 = i_wr && (i_addr == STC_ADDR_TAD0);
    wire wr_tad1 = i_wr && (i_addr == STC_ADDR_TAD1);
    wire wr_tad2 = i_wr && (i_addr == STC_ADDR_TAD2);
    wire wr_ramp = i_wr && (i_addr == STC_ADDR_RAMP);
    wire wr_istat = i_wr && (i_addr == STC_ADDR_IRQ_STAT);
    wire wr_imask = i_wr && (i_addr == STC_ADDR_IRQ_MASK);

    // Next values of the software registers
    wire en_nxt = wr_en ? i_wdata[0] : en_r;
    wire [7:0] cfg_nxt = wr_cfg ? {4'h0, i_wdata[3:0]} : cfg_r;
    wire [16:0] tad_nxt = {wr_tad2 ? i_wdata[0] : tad_r[16],
                           wr_tad1 ? i_wdata : tad_r[15:8],
                           wr_tad0 ? i_wdata : tad_r[7:0]};
    wire [7:0] ramp_nxt = wr_ramp ? i_wdata : ramp_r;
    wire [1:0] imask_nxt = wr_imask ? i_wdata[1:0] : irq_mask_r;

    // Software register storage; reserved bits are not kept
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            en_r <= STC_EN_RST[0];
            en_prev_r <= STC_EN_RST[0];
            cfg_r <= STC_CFG_RST;
            tad_r <= STC_TAD_RST;
            ramp_r <= STC_RAMP_RST;
            irq_mask_r <= STC_IRQ_RST;
        end
        else
        begin
            en_r <= en_nxt;
            en_prev_r <= en_r;
            cfg_r <= cfg_nxt;
            tad_r <= tad_nxt;
            ramp_r <= ramp_nxt;
            irq_mask_r <= imask_nxt;
        end
    end

    // ------------------------------------------------------------
    // Calibration control terms
    // ------------------------------------------------------------
    // A level of 1 alone never restarts; only the 0-to-1 step does
    wire cal_start = en_r & ~en_prev_r;
    wire [14:0] period_limit = stc_period_limit(run_cfg_r.accum_duration_select);
    wire [4:0] avg_sh = stc_log2_count(run_cfg_r.cal_averaging_select);
    wire [4:0] dur_sh = stc_log2_count(run_cfg_r.accum_duration_select);
    wire [4:0] total_sh = avg_sh + dur_sh;
    // Samples = averages x cycles per accumulation, minus one
    wire [15:0] samp_last = 16'((17'h00001 << total_sh) - 17'h00001);
    wire period_over = (period_cnt_r >= period_limit);
    wire [STC_ACC_W-1:0] acc_sum = acc_r + {16'h0000, i_phase_code};
    wire [STC_ACC_W-1:0] acc_avg = acc_sum >> total_sh;
    wire last_samp = (samp_cnt_r == samp_last);
    wire in_done = (state_r == STC_DONE);

    // Selects frozen at start, so a stray mid-run write cannot strand the counter
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
            run_cfg_r <= STC_CFG_RST;
        else if (cal_start)
            run_cfg_r <= cfg_r;
    end

    // Sequencer next state; a cleared enable always aborts to idle
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            STC_IDLE:
            begin
                if (cal_start)
                    state_nxt = STC_ARM;
            end
            STC_ARM:
            begin
                if (sysref_edge)
                    state_nxt = STC_ACCUM;
                else if (period_over)
                    state_nxt = STC_FAIL;
            end
            STC_ACCUM:
            begin
                if (sysref_edge && last_samp)
                    state_nxt = STC_DONE;
                else if (!sysref_edge && period_over)
                    state_nxt = STC_FAIL;
            end
            STC_DONE:
                state_nxt = STC_DONE;
            STC_FAIL:
                state_nxt = STC_FAIL;
            default:
                state_nxt = STC_IDLE;
        endcase
        if (!en_r)
            state_nxt = STC_IDLE;
    end

    // Events for the interrupt status register
    wire ev_done = (state_r == STC_ACCUM) && (state_nxt == STC_DONE);
    wire ev_fail = (state_r != STC_FAIL) && (state_nxt == STC_FAIL);
    wire [1:0] ev_vec = {ev_fail, ev_done};

    // State register
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
            state_r <= STC_IDLE;
        else
            state_r <= state_nxt;
    end

    // Period counter measures clocks since the last SYSREF edge
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
            period_cnt_r <= 15'h0000;
        else if (state_r == STC_IDLE || sysref_edge)
            period_cnt_r <= 15'h0000;
        else if (!period_over)
            period_cnt_r <= period_cnt_r + 15'h0001;
    end

    // Phase accumulation, one detector sample per SYSREF edge
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            acc_r <= '0;
            samp_cnt_r <= 16'h0000;
        end
        else if (state_r != STC_ACCUM)
        begin
            acc_r <= '0;
            samp_cnt_r <= 16'h0000;
        end
        else if (sysref_edge)
        begin
            acc_r <= acc_sum;
            samp_cnt_r <= samp_cnt_r + 16'h0001;
        end
    end

    // Result holds until the next successful run; the flag guards it
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
            cal_tad_r <= STC_TAD_RST;
        else if (ev_done)
            cal_tad_r <= acc_avg[STC_DELAY_W-1:0];
    end

    // ------------------------------------------------------------
    // Delay output selection
    // ------------------------------------------------------------
    // Manual register drives the line only while calibration is off
    wire [16:0] delay_nxt = en_r ? cal_tad_r : tad_r;

    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
            delay_r <= STC_TAD_RST;
        else
            delay_r <= delay_nxt;
    end

    // ------------------------------------------------------------
    // Interrupt status, mask and output
    // ------------------------------------------------------------
    // Write one to clear; a new event in the same cycle wins
    wire [1:0] istat_clr = wr_istat ? i_wdata[1:0] : 2'h0;
    wire [1:0] istat_nxt = (irq_stat_r & ~istat_clr) | ev_vec;
    wire irq_nxt = |(istat_nxt & irq_mask_r);

    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            irq_stat_r <= STC_IRQ_RST;
            irq_r <= 1'b0;
        end
        else
        begin
            irq_stat_r <= istat_nxt;
            irq_r <= irq_nxt;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Flag reads 1 only while enabled and finished
    stc_result_t result;
    assign result.reserved = 6'h00;
    assign result.cal_complete_flag = en_r && in_done;
    assign result.computed_delay_value = cal_tad_r;

    // Address decode for reads; unmapped and reserved read zero
    wire [23:0] res_bits = result;
    logic [7:0] rd_mux;

    always_comb
    begin
        if (i_addr == STC_ADDR_EN)
            rd_mux = {7'h00, en_r};
        else if (i_addr == STC_ADDR_CFG)
            rd_mux = cfg_r;
        else if (i_addr == STC_ADDR_RES0)
            rd_mux = res_bits[7:0];
        else if (i_addr == STC_ADDR_RES1)
            rd_mux = res_bits[15:8];
        else if (i_addr == STC_ADDR_RES2)
            rd_mux = res_bits[23:16];
        else if (i_addr == STC_ADDR_TAD0)
            rd_mux = tad_r[7:0];
        else if (i_addr == STC_ADDR_TAD1)
            rd_mux = tad_r[15:8];
        else if (i_addr == STC_ADDR_TAD2)
            rd_mux = {7'h00, tad_r[16]};
        else if (i_addr == STC_ADDR_RAMP)
            rd_mux = ramp_r;
        else if (i_addr == STC_ADDR_IRQ_STAT)
            rd_mux = {6'h00, irq_stat_r};
        else if (i_addr == STC_ADDR_IRQ_MASK)
            rd_mux = {6'h00, irq_mask_r};
        else
            rd_mux = 8'h00;
    end

    // Read data stand for exactly the cycle after the strobe
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
            rdata_r <= 8'h00;
        else if (i_rd)
            rdata_r <= rd_mux;
        else
            rdata_r <= 8'h00;
    end

    // Busy flag registered so the output comes from a flop
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
            active_r <= 1'b0;
        else
            active_r <= (state_nxt == STC_ARM) || (state_nxt == STC_ACCUM);
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_rdata = rdata_r;
    assign o_aperture_delay = delay_r;
    assign o_ramp_ctrl = ramp_r;
    assign o_cal_active = active_r;
    assign o_irq = irq_r;

endmodule // stc_sysref_cal

// ### sim/stc_sysref_src.sv
// SYSREF source and phase detector model driving the far side of the block
`timescale 1ns/1ps

module stc_sysref_src
(
    input wire logic i_clk, // Device clock
    input wire logic i_run, // Pulse train on while high
    input wire logic [7:0] i_period, // Pulse spacing in clocks
    input wire logic [16:0] i_code, // Phase code to present
    output logic o_sysref, // SYSREF pin
    output logic [16:0] o_phase_code // Phase detector code
);
    logic [7:0] cnt_r;

    // --------------------------------------------------------
    // Periodic pulse, two clocks high; silent when stopped
    // --------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        cnt_r <= (!i_run || cnt_r >= i_period - 8'h01) ? 8'h00 : cnt_r + 8'h01;
        o_sysref <= i_run && (cnt_r < 8'h02);
    end

    // Code changes with the run state so a stale sample shows up
    assign o_phase_code = i_run ? i_code : ~i_code;
endmodule // stc_sysref_src

// ### sim/stc_sysref_cal_assertions.sv
// Port-level checker for the SYSREF timing calibration block
`timescale 1ns/1ps

module stc_sysref_cal_checker
    import stc_pkg::*;
(
    input wire logic i_clk, // Device clock
    input wire logic i_resetn, // Synchronous reset, active low
    input wire logic [9:0] i_addr, // Register address
    input wire logic [7:0] i_wdata, // Write data
    input wire logic i_wr, // Write strobe
    input wire logic i_rd, // Read strobe
    input wire logic [7:0] o_rdata, // Read data
    input wire logic [16:0] o_aperture_delay, // Applied delay
    input wire logic o_cal_active, // Sequencer busy
    input wire logic o_irq // Interrupt
);
    logic en_r;
    logic [16:0] tad_r;
    logic [1:0] mask_r;

    // --------------------------------------------------------
    // Shadow of the writable registers the outputs depend on
    // --------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            en_r <= 1'b0;
            tad_r <= 17'h00000;
            mask_r <= 2'h0;
        end
        else if (i_wr)
        begin
            if (i_addr == STC_ADDR_EN) en_r <= i_wdata[0];
            if (i_addr == STC_ADDR_TAD0) tad_r[7:0] <= i_wdata;
            if (i_addr == STC_ADDR_TAD1) tad_r[15:8] <= i_wdata;
            if (i_addr == STC_ADDR_TAD2) tad_r[16] <= i_wdata[0];
            if (i_addr == STC_ADDR_IRQ_MASK) mask_r <= i_wdata[1:0];
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    // --------------------------------------------------------
    // Assertions
    // --------------------------------------------------------
    a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero outside read slot");
    a_unmapped_read_zero: assert property (i_rd && i_addr > STC_ADDR_RAMP && i_addr < STC_ADDR_IRQ_STAT
        |=> o_rdata == 8'h00)
        else $error("reserved address read not zero");
    a_cfg_reserved_zero: assert property (i_rd && i_addr == STC_ADDR_CFG |=> o_rdata[7:4] == 4'h0)
        else $error("configuration reserved bits not zero");
    a_manual_delay_path: assert property (!$past(en_r) |-> o_aperture_delay == $past(tad_r))
        else $error("aperture delay does not follow manual register");
    a_cal_off_idle: assert property (!en_r && !$past(en_r) && !$past(en_r, 2) |-> !o_cal_active)
        else $error("sequencer busy while disabled");
    a_enable_starts_cal: assert property ($rose(en_r) |-> ##[1:3] o_cal_active)
        else $error("enable rise did not start calibration");
    a_held_no_restart: assert property (en_r[*4] ##0 !o_cal_active |=> !o_cal_active)
        else $error("calibration restarted without enable rise");
    a_irq_masked_low: assert property ($past(mask_r) == 2'h0 |-> !o_irq)
        else $error("interrupt raised while masked");

    c_cal_run: cover property ($fell(o_cal_active));
    c_irq_seen: cover property ($rose(o_irq));
    c_manual_write: cover property (i_wr && i_addr == STC_ADDR_TAD2 && !en_r);
endmodule // stc_sysref_cal_checker

bind stc_sysref_cal stc_sysref_cal_checker u_chk (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_aperture_delay(o_aperture_delay),
    .o_cal_active(o_cal_active), .o_irq(o_irq));

// ### sim/tb.sv
// Self-checking bench for the SYSREF timing calibration block
`timescale 1ns/1ps

module tb;
    import stc_pkg::*;

    logic i_clk, i_resetn, i_wr, i_rd, i_sysref, o_cal_active, o_irq, run;
    logic [9:0] i_addr;
    logic [7:0] i_wdata, o_rdata, o_ramp_ctrl, period;
    logic [16:0] i_phase_code, o_aperture_delay, code;
    int failures = 0;
    int cmp_count = 0;
    int cyc = 0;

    stc_sysref_cal u_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .i_sysref(i_sysref), .i_phase_code(i_phase_code), .o_rdata(o_rdata),
        .o_aperture_delay(o_aperture_delay), .o_ramp_ctrl(o_ramp_ctrl), .o_cal_active(o_cal_active),
        .o_irq(o_irq));
    stc_sysref_src u_src (.i_clk(i_clk), .i_run(run), .i_period(period), .i_code(code),
        .o_sysref(i_sysref), .o_phase_code(i_phase_code));

    // --------------------------------------------------------
    // Clock and timeout
    // --------------------------------------------------------
    initial
    begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            failures++;
            conclude();
        end
    end

    // --------------------------------------------------------
    // Bus and compare tasks
    // --------------------------------------------------------
    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [9:0] a, input logic [7:0] exp, input string name);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk(name, {16'h0000, exp}, {16'h0000, o_rdata});
    endtask

    // Bounded wait for the interrupt line
    task automatic wait_irq(input int lim);
        int n;
        n = 0;
        while (o_irq !== 1'b1 && n < lim)
        begin
            @(posedge i_clk);
            n++;
        end
        chk("irq", 24'h1, {23'h0, o_irq});
    endtask

    task automatic conclude();
        if (failures == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // --------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------
    initial
    begin
        i_resetn = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 10'h000;
        i_wdata = 8'h00;
        run = 1'b0;
        period = 8'h14;
        code = 17'h0abcd;
        repeat (10) @(posedge i_clk);
        i_resetn <= 1'b1;
        // Reset values and reserved space
        rd(STC_ADDR_EN, 8'h00, "en");
        rd(STC_ADDR_CFG, 8'h05, "cfg");
        rd(STC_ADDR_TAD2, 8'h00, "tad2");
        rd(STC_ADDR_RAMP, 8'h00, "ramp");
        wr(10'h2b9, 8'hff);
        rd(10'h2b9, 8'h00, "reserved");
        wr(STC_ADDR_CFG, 8'hff);
        rd(STC_ADDR_CFG, 8'h0f, "cfg_w");
        wr(STC_ADDR_RAMP, 8'ha5);
        rd(STC_ADDR_RAMP, 8'ha5, "ramp_w");
        chk("ramp_out", 24'h0000a5, {16'h0, o_ramp_ctrl});
        // Manual delay drives the output while disabled
        wr(STC_ADDR_TAD0, 8'h34);
        wr(STC_ADDR_TAD1, 8'h12);
        wr(STC_ADDR_TAD2, 8'hff);
        rd(STC_ADDR_TAD2, 8'h01, "tad2_w");
        chk("manual", 24'h011234, {7'h0, o_aperture_delay});
        // Shortest averaging and duration so the run stays brief
        wr(STC_ADDR_CFG, 8'h00);
        wr(STC_ADDR_IRQ_MASK, 8'h03);
        run <= 1'b1;
        wr(STC_ADDR_EN, 8'h01);
        wait_irq(2000);
        rd(STC_ADDR_RES0, 8'hcd, "res0");
        rd(STC_ADDR_RES1, 8'hab, "res1");
        rd(STC_ADDR_RES2, 8'h02, "res2");
        chk("cal_out", 24'h00abcd, {7'h0, o_aperture_delay});
        wr(STC_ADDR_TAD0, 8'h00);
        repeat (3) @(posedge i_clk);
        chk("tad_ignored", 24'h00abcd, {7'h0, o_aperture_delay});
        rd(STC_ADDR_IRQ_STAT, 8'h01, "stat_done");
        wr(STC_ADDR_IRQ_STAT, 8'h01);
        @(posedge i_clk);
        chk("irq_clr", 24'h0, {23'h0, o_irq});
        // Rewriting one leaves the sequencer in done, not busy
        wr(STC_ADDR_EN, 8'h01);
        repeat (4) @(posedge i_clk);
        chk("no_restart", 24'h0, {23'h0, o_cal_active});
        // Clear then set again; silent source must fail on the gap limit
        wr(STC_ADDR_EN, 8'h00);
        rd(STC_ADDR_RES2, 8'h00, "flag_off");
        chk("manual_back", 24'h011200, {7'h0, o_aperture_delay});
        run <= 1'b0;
        wr(STC_ADDR_EN, 8'h01);
        repeat (4) @(posedge i_clk);
        chk("armed", 24'h1, {23'h0, o_cal_active});
        wait_irq(300);
        rd(STC_ADDR_IRQ_STAT, 8'h02, "stat_fail");
        rd(STC_ADDR_RES2[9:0], 8'h00, "flag_fail");
        wr(STC_ADDR_IRQ_MASK, 8'h00);
        repeat (2) @(posedge i_clk);
        chk("masked", 24'h0, {23'h0, o_irq});
        // Longer accumulation, and a delay whose top bit is set
        wr(STC_ADDR_EN, 8'h00);
        wr(STC_ADDR_IRQ_STAT, 8'h03);
        wr(STC_ADDR_IRQ_MASK, 8'h01);
        wr(STC_ADDR_CFG, 8'h01);
        code <= 17'h1f00f;
        run <= 1'b1;
        wr(STC_ADDR_EN, 8'h01);
        repeat (600) @(posedge i_clk);
        chk("dur_long", 24'h1, {23'h0, o_cal_active});
        wait_irq(2000);
        rd(STC_ADDR_RES0, 8'h0f, "res0_b");
        rd(STC_ADDR_RES1, 8'hf0, "res1_b");
        rd(STC_ADDR_RES2, 8'h03, "res2_b");
        chk("cal_out_b", 24'h01f00f, {7'h0, o_aperture_delay});
        conclude();
    end
endmodule // tb
